// *** include/mss_pkg.sv ***
package mss_pkg;

   // ----------------------------------------------------------------
   // Port counts and widths.
   // ----------------------------------------------------------------
   localparam int NUM_PORTS = 4;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int ID_W = 2;

   // ----------------------------------------------------------------
   // Master and slave port numbers.
   // ----------------------------------------------------------------
   localparam logic [1:0] MST_IFETCH = 2'h0;
   localparam logic [1:0] MST_LDST = 2'h1;
   localparam logic [1:0] MST_DMA = 2'h2;
   localparam logic [1:0] MST_ETH = 2'h3;
   localparam logic [1:0] SLV_FLASH = 2'h0;
   localparam logic [1:0] SLV_SRAM = 2'h1;
   localparam logic [1:0] SLV_VIDBUF = 2'h2;
   localparam logic [1:0] SLV_BRIDGE = 2'h3;

   // ----------------------------------------------------------------
   // Slave select field of the address and reset values.
   // ----------------------------------------------------------------
   localparam int SEL_HI = 31;
   localparam int SEL_LO = 30;
   localparam logic [1:0] RST_LAST_GNT = 2'h3;

   // ----------------------------------------------------------------
   // Per-slave transfer state, Gray coded along idle, issue, answer.
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ISSUE = 2'h1,
      ST_ACK = 2'h3
   } mss_state_t;

   // Picks the slave port that an address targets.
   function automatic logic [1:0] slvDecode(input logic [31:0] addr);
      slvDecode = addr[SEL_HI:SEL_LO];
   endfunction

endpackage

// *** verilog/mss_arbiter.sv ***
module mss_arbiter (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [3:0] req,
   input wire logic [3:0] elevate,
   input wire logic rrMode,
   input wire logic [1:0] lastGnt,
   output logic gntValid,
   output logic [1:0] gntId
);

   // ----------------------------------------------------------------
   // Winner selection.
   // ----------------------------------------------------------------
   // Elevated requesters form the candidate set when any exist, then the
   // search starts at master 0 or just after the last owner.
   always_comb begin
      logic [3:0] cand;
      logic [1:0] start;
      logic [1:0] idx;
      logic found;
      cand = (|(req & elevate)) ? (req & elevate) : req;
      start = rrMode ? 2'(lastGnt + 2'h1) : 2'h0;
      idx = 2'h0;
      found = 1'b0;
      gntId = 2'h0;
      for (int i = 0; i < 4; i++) begin
         idx = 2'(start + 2'(i));
         if (!found && cand[idx]) begin
            gntId = idx;
            found = 1'b1;
         end
      end
      gntValid = |cand;
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   property p_elevWins;
      (|(req & elevate)) |-> gntValid && elevate[gntId] && req[gntId];
   endproperty
   a_elevWins: assert property (p_elevWins) else $error("elevated master not chosen");

   property p_fixedOrder;
      !rrMode && !(|(req & elevate)) && (|req) |-> req[gntId] && ((req & ((4'h1 << gntId) - 4'h1)) == 4'h0);
   endproperty
   a_fixedOrder: assert property (p_fixedOrder) else $error("fixed order not lowest number");

   property p_rrRotate;
      rrMode && !(|(req & elevate)) && ((req & ~(4'h1 << lastGnt)) != 4'h0) |-> gntId != lastGnt;
   endproperty
   a_rrRotate: assert property (p_rrRotate) else $error("last owner chosen again");

endmodule

// *** verilog/mss_switch.sv ***
module mss_switch (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic rrMode,
   input wire logic [3:0] mReq,
   input wire logic [3:0][31:0] mAddr,
   input wire logic [3:0] mWrite,
   input wire logic [3:0][31:0] mWdata,
   input wire logic [3:0] mLast,
   input wire logic [3:0] mElevate,
   output logic [3:0] mAck,
   output logic [3:0][31:0] mRdata,
   output logic [3:0] sReq,
   output logic [3:0][31:0] sAddr,
   output logic [3:0] sWrite,
   output logic [3:0][31:0] sWdata,
   output logic [3:0] sLast,
   output logic [3:0][1:0] sOwner,
   input wire logic [3:0] sAck,
   input wire logic [3:0][31:0] sRdata
);

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   typedef struct packed {
      mss_pkg::mss_state_t [3:0] st;
      logic [3:0][1:0] owner;
      logic [3:0] locked;
      logic [3:0][1:0] lastGnt;
      logic [3:0] sReq;
      logic [3:0][31:0] sAddr;
      logic [3:0] sWrite;
      logic [3:0][31:0] sWdata;
      logic [3:0] sLast;
      logic [3:0] mAck;
      logic [3:0][31:0] mRdata;
   } mss_sw_t;

   mss_sw_t r;
   mss_sw_t n;
   logic [3:0][3:0] reqVec;
   logic [3:0] gntValid;
   logic [3:0][1:0] gntId;

   // ----------------------------------------------------------------
   // Request routing and one arbiter per slave port.
   // ----------------------------------------------------------------
   genvar gs;
   genvar gm;
   generate
      for (gs = 0; gs < mss_pkg::NUM_PORTS; gs++) begin : g_slv
         for (gm = 0; gm < mss_pkg::NUM_PORTS; gm++) begin : g_mst
            // Each master's address picks exactly one slave port.
            assign reqVec[gs][gm] = mReq[gm] && (mss_pkg::slvDecode(mAddr[gm]) == 2'(gs));
         end
         mss_arbiter u_arb (
            .clock(clock),
            .arst_n(arst_n),
            .req(reqVec[gs]),
            .elevate(mElevate),
            .rrMode(rrMode),
            .lastGnt(r.lastGnt[gs]),
            .gntValid(gntValid[gs]),
            .gntId(gntId[gs])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state.
   // ----------------------------------------------------------------
   // Every slave port runs its own sequence, so distinct pairs overlap.
   always_comb begin
      logic [1:0] pick;
      logic go;
      pick = 2'h0;
      go = 1'b0;
      n = r;
      n.mAck = 4'h0;
      for (int s = 0; s < mss_pkg::NUM_PORTS; s++) begin
         go = 1'b0;
         pick = r.owner[s];
         case (r.st[s])
            mss_pkg::ST_IDLE: begin
               if (r.locked[s]) begin
                  // Owner keeps the port; other requesters stay stalled.
                  go = reqVec[s][r.owner[s]];
               end else begin
                  // Grants are made only here, between transactions.
                  go = gntValid[s];
                  pick = gntId[s];
               end
               if (go) begin
                  n.owner[s] = pick;
                  n.sReq[s] = 1'b1;
                  n.sAddr[s] = mAddr[pick];
                  n.sWrite[s] = mWrite[pick];
                  n.sWdata[s] = mWdata[pick];
                  n.sLast[s] = mLast[pick];
                  n.st[s] = mss_pkg::ST_ISSUE;
               end
            end
            mss_pkg::ST_ISSUE: begin
               if (sAck[s]) begin
                  // Return the answer and decide whether the owner keeps the port.
                  n.sReq[s] = 1'b0;
                  n.mAck[r.owner[s]] = 1'b1;
                  n.mRdata[r.owner[s]] = sRdata[s];
                  n.locked[s] = !r.sLast[s];
                  if (r.sLast[s]) begin
                     n.lastGnt[s] = r.owner[s];
                  end
                  n.st[s] = mss_pkg::ST_ACK;
               end
            end
            mss_pkg::ST_ACK: begin
               // The master updates its request during this cycle.
               n.st[s] = mss_pkg::ST_IDLE;
            end
            default: begin
               n.st[s] = mss_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------
   // Reset leaves every slave idle and unowned, in fixed priority order.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.lastGnt <= {4{mss_pkg::RST_LAST_GNT}};
      end else begin
         r <= n;
      end
   end

   // Outputs come straight from the state register.
   assign mAck = r.mAck;
   assign mRdata = r.mRdata;
   assign sReq = r.sReq;
   assign sAddr = r.sAddr;
   assign sWrite = r.sWrite;
   assign sWdata = r.sWdata;
   assign sLast = r.sLast;
   assign sOwner = r.owner;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   generate
      for (gs = 0; gs < mss_pkg::NUM_PORTS; gs++) begin : g_chk
         sequence s_answered;
            r.st[gs] == mss_pkg::ST_ISSUE && sAck[gs];
         endsequence

         sequence s_returned;
            (mAck[r.owner[gs]] && !sReq[gs]) ##1 (r.st[gs] == mss_pkg::ST_IDLE);
         endsequence

         property p_ackPath;
            s_answered |=> s_returned;
         endproperty
         a_ackPath: assert property (p_ackPath) else $error("answer not returned to owner");

         property p_decode;
            sReq[gs] |-> mss_pkg::slvDecode(sAddr[gs]) == 2'(gs);
         endproperty
         a_decode: assert property (p_decode) else $error("request sent to wrong slave");

         property p_addrPass;
            $rose(sReq[gs]) |-> sAddr[gs] == mAddr[r.owner[gs]] &&
               sWdata[gs] == mWdata[r.owner[gs]] && sWrite[gs] == mWrite[r.owner[gs]] &&
               sLast[gs] == mLast[r.owner[gs]];
         endproperty
         a_addrPass: assert property (p_addrPass) else $error("address or data not passed");

         property p_lockHold;
            r.locked[gs] |=> r.owner[gs] == $past(r.owner[gs]);
         endproperty
         a_lockHold: assert property (p_lockHold) else $error("locked slave changed owner");

         property p_idle;
            r.st[gs] == mss_pkg::ST_IDLE && reqVec[gs] == 4'h0 |=> !sReq[gs];
         endproperty
         a_idle: assert property (p_idle) else $error("slave busy without request");

         property p_boundary;
            r.st[gs] != mss_pkg::ST_IDLE |=> r.owner[gs] == $past(r.owner[gs]);
         endproperty
         a_boundary: assert property (p_boundary) else $error("owner changed mid transfer");
      end
   endgenerate

endmodule

// *** verif/mss_slave_model.sv ***
// Behavioural model of the four slaves behind the switch.
module mss_slave_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [3:0] slow,
   input wire logic [3:0] sReq,
   input wire logic [3:0][31:0] sAddr,
   input wire logic [3:0] sWrite,
   input wire logic [3:0][31:0] sWdata,
   output logic [3:0] sAck,
   output logic [3:0][31:0] sRdata,
   output logic [3:0][31:0] wrSeen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0][1:0] waitCnt;

   // Each slave answers a held request once, after two waits when slow; between answers the
   // read data toggles every cycle so that a stale value can never pass for a fresh one.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sAck <= 4'h0;
         sRdata <= '0;
         wrSeen <= '0;
         waitCnt <= '0;
      end else begin
         for (int s = 0; s < 4; s++) begin
            sAck[s] <= 1'b0;
            sRdata[s] <= ~sRdata[s];
            if (sReq[s] && !sAck[s]) begin
               if (waitCnt[s] == (slow[s] ? 2'h2 : 2'h0)) begin
                  sAck[s] <= 1'b1;
                  sRdata[s] <= sAddr[s] ^ 32'h6C3E_A915;
                  waitCnt[s] <= 2'h0;
                  if (sWrite[s]) begin
                     wrSeen[s] <= sWdata[s];
                  end
               end else begin
                  waitCnt[s] <= waitCnt[s] + 2'h1;
               end
            end
         end
      end
   end
endmodule

// *** verif/mss_switch_bench.sv ***
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end

module mss_switch_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, arst_n, rrMode;
   logic [3:0] mReq, mWrite, mLast, mElevate, mAck, sReq, sWrite, sLast, sAck, slow;
   logic [3:0][31:0] mAddr, mWdata, mRdata, sAddr, sWdata, sRdata, wrSeen;
   logic [3:0][1:0] sOwner;
   logic [1:0] gLog[4][$];
   int fails = 0;
   int checked = 0;
   int cycles = 0;

   // ----------------------------------------------------------------
   // Design, slaves, clock and watchdog.
   // ----------------------------------------------------------------
   mss_switch mss_switch_inst (.clock(clock), .arst_n(arst_n), .rrMode(rrMode), .mReq(mReq),
      .mAddr(mAddr), .mWrite(mWrite), .mWdata(mWdata), .mLast(mLast), .mElevate(mElevate),
      .mAck(mAck), .mRdata(mRdata), .sReq(sReq), .sAddr(sAddr), .sWrite(sWrite),
      .sWdata(sWdata), .sLast(sLast), .sOwner(sOwner), .sAck(sAck), .sRdata(sRdata));
   mss_slave_model mss_slave_model_inst (.clock(clock), .arst_n(arst_n), .slow(slow),
      .sReq(sReq), .sAddr(sAddr), .sWrite(sWrite), .sWdata(sWdata), .sAck(sAck),
      .sRdata(sRdata), .wrSeen(wrSeen));

   always #20 clock = ~clock;

   // Logs the owner of every answered slave transfer and cuts a hang short.
   always @(posedge clock) begin
      cycles++;
      for (int s = 0; s < 4; s++) begin
         if (sReq[s] === 1'b1 && sAck[s] === 1'b1) begin
            gLog[s].push_back(sOwner[s]);
         end
      end
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   function automatic logic [31:0] wdOf(input logic [31:0] a);
      return {a[15:0], a[31:16]} ^ 32'hC3A5_96F0;
   endfunction

   // One master transfer, held until its acknowledge is sampled.
   task automatic xfer(input int m, input logic [31:0] a, input logic w, input logic l,
                       output logic [31:0] rd, output int n);
      n = 0;
      @(posedge clock);
      mReq[m] <= 1'b1;
      mAddr[m] <= a;
      mWrite[m] <= w;
      mWdata[m] <= wdOf(a);
      mLast[m] <= l;
      do begin
         @(posedge clock);
         n++;
      end while (mAck[m] !== 1'b1 && n < 200);
      rd = mRdata[m];
      mReq[m] <= 1'b0;
      if (n >= 200) begin
         fails++;
      end
   endtask

   task automatic chk_order(input int s, input logic [15:0] seq, input int k);
      `CHK("grant count", k, gLog[s].size())
      for (int i = 0; i < k; i++) begin
         `CHK("grant owner", seq[2*i+:2], gLog[s][i])
      end
      gLog[s].delete();
   endtask

   task automatic do_reset();
      @(posedge clock);
      arst_n <= 1'b0;
      mReq <= 4'h0;
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
   endtask

   task automatic stop_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   task automatic t_parallel();
      logic [31:0] rd[4];
      int n[4];
      fork
         xfer(0, 32'h4000_0010, 1'b0, 1'b1, rd[0], n[0]);
         xfer(1, 32'h8000_0124, 1'b1, 1'b1, rd[1], n[1]);
         xfer(2, 32'hC000_0208, 1'b0, 1'b1, rd[2], n[2]);
         xfer(3, 32'h0000_0F3C, 1'b1, 1'b1, rd[3], n[3]);
      join
      `CHK("rdata m0", 32'h4000_0010 ^ 32'h6C3E_A915, rd[0])
      `CHK("rdata m2", 32'hC000_0208 ^ 32'h6C3E_A915, rd[2])
      `CHK("wdata s2", wdOf(32'h8000_0124), wrSeen[2])
      `CHK("wdata s0", wdOf(32'h0000_0F3C), wrSeen[0])
      for (int m = 1; m < 4; m++) begin
         `CHK("latency", n[0], n[m])
      end
      chk_order(1, 16'h0000, 1);
      chk_order(3, 16'h0002, 1);
      gLog[0].delete();
      gLog[2].delete();
      `CHK("idle slaves", 4'h0, sReq)
      $display("end of parallel test");
   endtask

   task automatic t_fixed();
      logic [31:0] rd[4];
      int n[4];
      fork
         xfer(3, 32'h4000_0300, 1'b0, 1'b1, rd[3], n[3]);
         xfer(2, 32'h4000_0200, 1'b0, 1'b1, rd[2], n[2]);
         xfer(1, 32'h4000_0100, 1'b0, 1'b1, rd[1], n[1]);
         xfer(0, 32'h4000_0000, 1'b0, 1'b1, rd[0], n[0]);
      join
      chk_order(1, 16'h00E4, 4);
      $display("end of fixed priority test");
   endtask

   task automatic t_lock();
      logic [31:0] rd;
      logic [31:0] rq;
      int n;
      int q;
      fork
         begin
            xfer(2, 32'h0000_0040, 1'b1, 1'b0, rd, n);
            xfer(2, 32'h0000_0044, 1'b1, 1'b1, rd, n);
         end
         begin
            @(posedge clock);
            xfer(0, 32'h0000_0080, 1'b0, 1'b1, rq, q);
         end
      join
      chk_order(0, 16'h000A, 3);
      `CHK("rdata m0", 32'h0000_0080 ^ 32'h6C3E_A915, rq)
      $display("end of locked ownership test");
   endtask

   task automatic t_elev();
      logic [31:0] rd[2];
      int n[2];
      slow <= 4'h4;
      for (int r = 0; r < 2; r++) begin
         mElevate <= (r == 0) ? 4'h8 : 4'h0;
         fork
            xfer(0, 32'h8000_0500, 1'b0, 1'b1, rd[0], n[0]);
            xfer(3, 32'h8000_0504, 1'b0, 1'b1, rd[1], n[1]);
         join
      end
      chk_order(2, 16'h00C3, 4);
      slow <= 4'h0;
      $display("end of elevation test");
   endtask

   task automatic t_rr();
      logic [31:0] rd[4];
      int n[4];
      do_reset();
      rrMode <= 1'b1;
      fork
         repeat (2) xfer(0, 32'hC000_0000, 1'b0, 1'b1, rd[0], n[0]);
         repeat (2) xfer(1, 32'hC000_0010, 1'b0, 1'b1, rd[1], n[1]);
         repeat (2) xfer(2, 32'hC000_0020, 1'b0, 1'b1, rd[2], n[2]);
         repeat (2) xfer(3, 32'hC000_0030, 1'b0, 1'b1, rd[3], n[3]);
      join
      chk_order(3, 16'hE4E4, 8);
      rrMode <= 1'b0;
      $display("end of round robin test");
   endtask

   // Main sequence.
   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      rrMode = 1'b0;
      mReq = 4'h0;
      mAddr = '0;
      mWrite = 4'h0;
      mWdata = '0;
      mLast = 4'h0;
      mElevate = 4'h0;
      slow = 4'h0;
      do_reset();
      t_parallel();
      t_fixed();
      t_lock();
      t_elev();
      t_rr();
      stop_test();
   end
endmodule
